/* File: logic/mbch_bus_ctrl.sv */
/*
 * Minimum-mode local bus control: transceiver direction and enable,
 * cycle status lines and the hold request / acknowledge handshake.
 * Assumes a core on i_clk_sys that offers one bus cycle at a time and
 * a pad ring that resolves each output with its enable (a released
 * line is weakly kept at logic one by the pad).
 */
`timescale 1ns/100ps

module mbch_bus_ctrl (
    // Clock and reset
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_srst,
    // Bus cycle request from the core
    input  wire logic                  i_cyc_valid,
    input  wire mbch_pkg::mbch_status_t i_cyc_status,
    input  wire logic                  i_cyc_ready_pin,
    output logic                       o_cyc_ready,
    output logic                       o_cyc_done,
    // Hold handshake pins
    input  wire logic                  i_hold_request,
    output logic                       o_hold_ack,
    // Cycle status pins
    output logic                       o_io_memory_select,
    output logic                       o_io_memory_select_oe,
    output logic                       o_status_line_zero,
    output logic                       o_status_line_zero_oe,
    // Transceiver control pins
    output logic                       o_xmit_recv_dir,
    output logic                       o_xmit_recv_dir_oe,
    output logic                       o_xcvr_data_enable_n,
    output logic                       o_xcvr_data_enable_n_oe
);

    mbch_pkg::mbch_bus_state_e state_q;
    mbch_pkg::mbch_bus_state_e state_d;
    mbch_pkg::mbch_status_t    status_q;
    logic                      phase_q;
    logic                      phase_d;
    logic                      hold_meta_q;
    logic                      hold_sync_q;
    logic                      rdy_meta_q;
    logic                      rdy_sync_q;
    logic                      hold_ack_q;
    logic                      drive_q;
    logic                      iom_q;
    logic                      dir_q;
    logic                      ss0_q;
    logic                      den_n_q;
    logic                      done_q;
    logic                      state_end;
    logic                      hold_take;
    logic                      hold_free;
    logic                      cyc_take;
    logic                      at_boundary;
    logic                      is_transfer;
    logic                      is_write;
    logic                      den_on_d;

    // Both pin inputs pass two flops before any logic reads them
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            hold_meta_q <= 1'b0;
            hold_sync_q <= 1'b0;
        end else begin
            hold_meta_q <= i_hold_request;
            hold_sync_q <= hold_meta_q;
        end
    end

    // A slow ready pin adds whole wait states; only the second flop is read
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            rdy_meta_q <= 1'b0;
            rdy_sync_q <= 1'b0;
        end else begin
            rdy_meta_q <= i_cyc_ready_pin;
            rdy_sync_q <= rdy_meta_q;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            phase_q <= mbch_pkg::PH_FIRST;
        end else begin
            phase_q <= phase_d;
        end
    end

    assign phase_d     = ~phase_q;
    assign state_end   = (phase_q == mbch_pkg::PH_SECOND);
    assign at_boundary = (state_q == mbch_pkg::BS_IDLE) || (state_q == mbch_pkg::BS_T4);

    // Idle states count as T4 for the grant; the request is held high by the master
    assign hold_take   = (phase_q == mbch_pkg::PH_FIRST) && at_boundary && hold_sync_q;
    assign hold_free   = (state_q == mbch_pkg::BS_HOLD) && state_end && !hold_sync_q;

    // Acceptance only in the second half, so a grant taken mid-state always wins
    assign o_cyc_ready = at_boundary && state_end && !hold_ack_q;
    assign cyc_take    = o_cyc_ready && i_cyc_valid;

    always_comb begin
        state_d = state_q;
        if (hold_take) begin
            state_d = mbch_pkg::BS_HOLD;
        end else if (state_end) begin
            case (state_q)
                mbch_pkg::BS_IDLE: begin
                    if (i_cyc_valid) begin
                        state_d = mbch_pkg::BS_PRE;
                    end
                end
                mbch_pkg::BS_PRE: begin
                    state_d = mbch_pkg::BS_T1;
                end
                mbch_pkg::BS_T1: begin
                    state_d = mbch_pkg::BS_T2;
                end
                mbch_pkg::BS_T2: begin
                    state_d = mbch_pkg::BS_T3;
                end
                mbch_pkg::BS_T3, mbch_pkg::BS_TW: begin
                    state_d = rdy_sync_q ? mbch_pkg::BS_T4 : mbch_pkg::BS_TW;
                end
                mbch_pkg::BS_T4: begin
                    state_d = i_cyc_valid ? mbch_pkg::BS_PRE : mbch_pkg::BS_IDLE;
                end
                mbch_pkg::BS_HOLD: begin
                    if (!hold_sync_q) begin
                        state_d = mbch_pkg::BS_IDLE;
                    end
                end
                default: begin
                    state_d = mbch_pkg::BS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            state_q <= mbch_pkg::BS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Cycle completes on leaving T4, whether to a new cycle, idle or a hold
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (state_q == mbch_pkg::BS_T4) && (state_d != mbch_pkg::BS_T4);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            status_q <= mbch_pkg::ST_PASSIVE;
        end else if (cyc_take) begin
            status_q <= i_cyc_status;
        end
    end

    // Hold acknowledge and the release of every control line share one edge
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            hold_ack_q <= 1'b0;
        end else if (hold_take) begin
            hold_ack_q <= 1'b1;
        end else if (hold_free) begin
            hold_ack_q <= 1'b0;
        end
    end

    // Lines stay released after reset and after a hold until a cycle is taken
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            drive_q <= 1'b0;
        end else if (hold_take) begin
            drive_q <= 1'b0;
        end else if (cyc_take) begin
            drive_q <= 1'b1;
        end
    end

    // Status lines load in the state before T1 and hold until the next cycle is taken or a hold is granted
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            iom_q <= mbch_pkg::FLOAT_LEVEL;
        end else if (hold_take) begin
            iom_q <= mbch_pkg::FLOAT_LEVEL;
        end else if (cyc_take) begin
            iom_q <= ~i_cyc_status[mbch_pkg::STB_S2];
        end
    end

    // Direction shares every load and release point with io/memory
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            dir_q <= mbch_pkg::FLOAT_LEVEL;
        end else if (hold_take) begin
            dir_q <= mbch_pkg::FLOAT_LEVEL;
        end else if (cyc_take) begin
            dir_q <= i_cyc_status[mbch_pkg::STB_S1];
        end
    end

    // Status zero passes the code bit through uninverted
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            ss0_q <= mbch_pkg::FLOAT_LEVEL;
        end else if (hold_take) begin
            ss0_q <= mbch_pkg::FLOAT_LEVEL;
        end else if (cyc_take) begin
            ss0_q <= i_cyc_status[mbch_pkg::STB_S0];
        end
    end

    // Halt and passive codes run the state sequence with no data transfer
    always_comb begin
        is_transfer = 1'b0;
        is_write    = 1'b0;
        case (status_q)
            // Code fetches are memory reads as far as the transceiver is concerned
            mbch_pkg::ST_INT_ACK, mbch_pkg::ST_RD_IO, mbch_pkg::ST_CODE, mbch_pkg::ST_RD_MEM: begin
                is_transfer = 1'b1;
                is_write    = 1'b0;
            end
            mbch_pkg::ST_WR_IO, mbch_pkg::ST_WR_MEM: begin
                is_transfer = 1'b1;
                is_write    = 1'b1;
            end
            mbch_pkg::ST_HALT, mbch_pkg::ST_PASSIVE: begin
                is_transfer = 1'b0;
                is_write    = 1'b0;
            end
            default: begin
                is_transfer = 1'b0;
                is_write    = 1'b0;
            end
        endcase
    end

    // Decoded from the next state so the enable flop switches on the half-state edge
    always_comb begin
        den_on_d = 1'b0;
        case (state_d)
            mbch_pkg::BS_T2: begin
                den_on_d = is_write || (phase_d == mbch_pkg::PH_SECOND);
            end
            mbch_pkg::BS_T3, mbch_pkg::BS_TW: begin
                den_on_d = 1'b1;
            end
            mbch_pkg::BS_T4: begin
                den_on_d = (phase_d == mbch_pkg::PH_FIRST);
            end
            default: begin
                den_on_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            den_n_q <= mbch_pkg::FLOAT_LEVEL;
        end else begin
            den_n_q <= ~(den_on_d && is_transfer);
        end
    end

    assign o_cyc_done              = done_q;
    assign o_hold_ack              = hold_ack_q;
    assign o_io_memory_select      = iom_q;
    assign o_io_memory_select_oe   = drive_q;
    assign o_xmit_recv_dir         = dir_q;
    assign o_xmit_recv_dir_oe      = drive_q;
    assign o_status_line_zero      = ss0_q;
    assign o_status_line_zero_oe   = drive_q;
    assign o_xcvr_data_enable_n    = den_n_q;
    assign o_xcvr_data_enable_n_oe = drive_q;

endmodule

/* File: logic/mbch_pkg.sv */
/*
 * Constants for the minimum-mode local bus control and hold block:
 * bus cycle status codes, half-state phase encoding and pin levels.
 * Assumes users reference every item as mbch_pkg::name.
 */
package mbch_pkg;

    // Three-bit cycle status, bit 2..0 = max-mode status lines 2..0
    typedef logic [2:0] mbch_status_t;

    localparam mbch_status_t ST_INT_ACK   = 3'h0;
    localparam mbch_status_t ST_RD_IO     = 3'h1;
    localparam mbch_status_t ST_WR_IO     = 3'h2;
    localparam mbch_status_t ST_HALT      = 3'h3;
    localparam mbch_status_t ST_CODE      = 3'h4;
    localparam mbch_status_t ST_RD_MEM    = 3'h5;
    localparam mbch_status_t ST_WR_MEM    = 3'h6;
    localparam mbch_status_t ST_PASSIVE   = 3'h7;

    // Field positions inside a status code
    localparam int unsigned  STB_S2       = 2;
    localparam int unsigned  STB_S1       = 1;
    localparam int unsigned  STB_S0       = 0;

    // Each processor clock state spans two system clocks
    localparam logic         PH_FIRST     = 1'b0;
    localparam logic         PH_SECOND    = 1'b1;

    // Level a floated control line is weakly held at
    localparam logic         FLOAT_LEVEL  = 1'b1;

    typedef enum logic [2:0] {
        BS_IDLE,
        BS_PRE,
        BS_T1,
        BS_T2,
        BS_T3,
        BS_TW,
        BS_T4,
        BS_HOLD
    } mbch_bus_state_e;

endpackage

/* File: tb/mbch_bus_ctrl_asserts.sv */
/* Port checker for mbch_bus_ctrl: cycle status, enable timing, hold.
   Assumes it is bound to every instance of that module. */
`timescale 1ns/100ps
module mbch_bus_ctrl_asserts (
    // Clock and reset
    input wire logic                   i_clk_sys,
    input wire logic                   i_srst,
    // Core side
    input wire logic                   i_cyc_valid,
    input wire mbch_pkg::mbch_status_t i_cyc_status,
    input wire logic                   i_cyc_ready_pin,
    input wire logic                   o_cyc_ready,
    input wire logic                   o_cyc_done,
    // Pins
    input wire logic                   i_hold_request,
    input wire logic                   o_hold_ack,
    input wire logic                   o_io_memory_select,
    input wire logic                   o_io_memory_select_oe,
    input wire logic                   o_status_line_zero,
    input wire logic                   o_status_line_zero_oe,
    input wire logic                   o_xmit_recv_dir,
    input wire logic                   o_xmit_recv_dir_oe,
    input wire logic                   o_xcvr_data_enable_n,
    input wire logic                   o_xcvr_data_enable_n_oe
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    wire tk  = o_cyc_ready && i_cyc_valid;
    wire xcvr_data_enable = !o_xcvr_data_enable_n;
    sequence rd_take; tk && !i_cyc_status[1]; endsequence
    sequence wr_take; tk && i_cyc_status[1:0] == 2'h2; endsequence
    status_code_a: assert property (tk |=>
        {o_io_memory_select, o_xmit_recv_dir, o_status_line_zero, o_io_memory_select_oe}
        == {~$past(i_cyc_status[2]), $past(i_cyc_status[1:0]), 1'b1}) else $error("status pins wrong");
    dir_track_a: assert property (
        o_xmit_recv_dir_oe == o_io_memory_select_oe &&
        (!$changed(o_xmit_recv_dir) || $past(tk) || $rose(o_hold_ack))) else $error("direction timing differs");
    rd_den_a: assert property (rd_take ##1 (!o_hold_ack)[*5] |->
        o_xcvr_data_enable_n ##1 xcvr_data_enable) else $error("read enable start wrong");
    wr_den_a: assert property (wr_take ##1 (!o_hold_ack)[*4] |->
        o_xcvr_data_enable_n ##1 xcvr_data_enable) else $error("write enable start wrong");
    den_end_a: assert property ((rd_take or wr_take) ##1
        (i_cyc_ready_pin && !i_hold_request && !o_hold_ack)[*7] |->
        xcvr_data_enable[*3] ##1 !xcvr_data_enable ##1 o_cyc_done) else $error("enable end wrong");
    no_den_a: assert property (tk && i_cyc_status[1:0] == 2'h3 |=>
        o_xcvr_data_enable_n[*8]) else $error("enable on idle cycle");
    hold_float_a: assert property (o_hold_ack |-> !o_cyc_ready && o_xmit_recv_dir &&
        o_status_line_zero && o_xcvr_data_enable_n && !o_xcvr_data_enable_n_oe && !o_io_memory_select_oe
        && !o_status_line_zero_oe && !o_xmit_recv_dir_oe) else $error("driven during hold");
    oe_cause_a: assert property ($rose(o_io_memory_select_oe) |-> $past(tk))
        else $error("drive without cycle");
    hold_grant_a: assert property (i_hold_request[*8] |-> ##[0:30] o_hold_ack)
        else $error("hold not granted");
    hold_drop_a: assert property ((o_hold_ack && !i_hold_request)[*4] |-> ##[0:4] !o_hold_ack)
        else $error("hold not dropped");
endmodule
bind mbch_bus_ctrl mbch_bus_ctrl_asserts u_chk (.*);

/* File: tb/mbch_hold_master.sv */
/* Model of a second master that borrows the local bus.
   Assumes the bench sets the hold length and raises i_want. */
`timescale 1ns/100ps
module mbch_hold_master (
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_srst,
    // Bench control
    input  wire logic       i_want,
    input  wire logic [7:0] i_len,
    // Hold pins
    input  wire logic       i_hold_ack,
    output logic            o_hold_request
);
    logic [7:0] cnt_q;
    // Launched on the clock edge, so set-up is met without a synchroniser
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || !i_want) begin
            o_hold_request <= 1'b0;
            cnt_q          <= 8'h00;
        end else if (cnt_q < i_len) begin
            o_hold_request <= 1'b1;
            cnt_q          <= cnt_q + {7'h00, i_hold_ack};
        end else begin
            o_hold_request <= 1'b0;
        end
    end
endmodule

/* File: tb/tb_min_mode_bus_control_hold.sv */
/* Bench for mbch_bus_ctrl: all cycle codes, random back-to-back, holds.
   Assumes the checker is bound and the hold master is compiled. */
`timescale 1ns/100ps
module tb_min_mode_bus_control_hold;
    logic i_clk_sys = 1'b0, i_srst = 1'b1, i_cyc_valid = 1'b0, i_cyc_ready_pin = 1'b1;
    mbch_pkg::mbch_status_t i_cyc_status = 3'h7;
    logic o_cyc_ready, o_cyc_done, i_hold_request, o_hold_ack, o_io_memory_select, o_io_memory_select_oe;
    logic o_status_line_zero, o_status_line_zero_oe, o_xmit_recv_dir, o_xmit_recv_dir_oe;
    logic o_xcvr_data_enable_n, o_xcvr_data_enable_n_oe, want = 1'b0, tk_q = 1'b0;
    logic [7:0] len = 8'h02, lfsr = 8'h34;
    logic [5:0] seen = 6'h00, exp_q[$];
    int err_total = 0, comparisons = 0;
    wire [7:0] pins = {o_io_memory_select_oe, o_status_line_zero_oe, o_xmit_recv_dir_oe, o_xcvr_data_enable_n_oe,
                       o_io_memory_select, o_status_line_zero, o_xmit_recv_dir, o_xcvr_data_enable_n};
    always #2.5 i_clk_sys = ~i_clk_sys;
    mbch_bus_ctrl DUT (.*);
    mbch_hold_master u_master (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_want(want), .i_len(len),
                               .i_hold_ack(o_hold_ack), .o_hold_request(i_hold_request));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    // Note: {io/mem, direction, status zero, enable-low clock count}; each wait state adds two clocks
    task automatic take(input logic [2:0] c, input logic [2:0] tw = 3'h0);
        int n;
        logic [2:0] cnt;
        n   = 0;
        cnt = (c[1:0] == 2'h3) ? 3'h0 : (c[1:0] == 2'h2) ? 3'h5 : 3'h4;
        if (c[1:0] != 2'h3) cnt = cnt + {tw[1:0], 1'b0};
        i_cyc_valid  <= 1'b1;
        i_cyc_status <= c;
        exp_q.push_back({~c[2], c[1:0], cnt});
        do begin
            @(negedge i_clk_sys);
            n++;
        end while (!o_cyc_ready && n < 200);
        if (n >= 200) err_total++;
        @(posedge i_clk_sys);
    endtask
    task automatic wait_ack(input logic v);
        int n;
        n = 0;
        do begin
            @(negedge i_clk_sys);
            n++;
        end while (o_hold_ack !== v && n < 200);
        if (n >= 200) err_total++;
    endtask
    always @(posedge i_clk_sys) tk_q <= o_cyc_ready && i_cyc_valid;
    always @(negedge i_clk_sys) begin
        if (o_cyc_done) check({2'h0, seen}, {2'h0, exp_q.pop_front()});
        if (tk_q) begin
            check(pins[7:5], 8'h07);
            seen = {o_io_memory_select, o_xmit_recv_dir, o_status_line_zero, 3'h0};
        end else if (!o_xcvr_data_enable_n) seen = seen + 6'h01;
    end
    // Over forty times the expected run, so a slow hold never trips it
    initial begin
        #100000;
        err_total++;
        tally_and_finish;
    end
    initial begin
        repeat (20) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        @(negedge i_clk_sys);
        check(pins, 8'h0f);
        @(posedge i_clk_sys);
        for (int i = 0; i < 8; i++) take(i[2:0]);
        $display("test all codes done");
        for (int i = 0; i < 12; i++) begin
            lfsr = lfsr_next(lfsr);
            take(lfsr[2:0]);
        end
        $display("test random back-to-back done");
        take(3'h5, 3'h1);
        i_cyc_valid     <= 1'b0;
        i_cyc_ready_pin <= 1'b0;
        repeat (6) @(posedge i_clk_sys);
        i_cyc_ready_pin <= 1'b1;
        repeat (12) @(posedge i_clk_sys);
        want <= 1'b1;
        $display("test wait state done");
        wait_ack(1'b1);
        check(pins, 8'h0f);
        wait_ack(1'b0);
        check(pins, 8'h0f);
        @(posedge i_clk_sys);
        want <= 1'b0;
        len  <= 8'h28;
        @(posedge i_clk_sys);
        want <= 1'b1;
        for (int i = 4; i < 8; i++) take(i[2:0]);
        i_cyc_valid <= 1'b0;
        repeat (120) @(posedge i_clk_sys);
        check(8'(exp_q.size()), 8'h00);
        $display("test hold done");
        tally_and_finish;
    end
endmodule
